// >>> vad_pkg.sv
// Purpose: shared types and constants for the pseudo-float pole test block
// Assumes: 20 MHz clock, one frame per start strobe
// Notes: pseudo-float value = 2^e * m / 32768, with m >= 16384 or zero

package vad_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int NLAG = 9;
  localparam int ACC_W = 72;

  // ------------------------------------------------------------
  // pseudo-float format and constants
  // ------------------------------------------------------------
  localparam int MANT_FRAC = 15;
  localparam logic signed [15:0] MANT_MIN = 16'sh4000;
  localparam logic signed [15:0] ZERO_EXP = 16'sh8000;
  // energy floor, threshold margin, threshold floor
  localparam logic signed [15:0] E_FLOOR = 16'sh0011;
  localparam logic signed [15:0] M_FLOOR = 16'sh7EF4;
  localparam logic signed [15:0] E_MARGIN = 16'sh001B;
  localparam logic signed [15:0] M_MARGIN = 16'sh421F;
  localparam logic signed [15:0] E_THFLOOR = 16'sh0013;
  localparam logic signed [15:0] M_THFLOOR = 16'sh54A3;

  // ------------------------------------------------------------
  // tone test thresholds, Q15
  // ------------------------------------------------------------
  localparam logic [15:0] FREQTH_Q15 = 16'h0C74;
  localparam logic [15:0] PREDTH_Q15 = 16'h05B9;
  // energy filter coefficients are Q12, so lag products are Q24
  localparam int ENERGY_FRAC = 24;
  // cycles from accepted start to the done pulse
  localparam int DONE_LATENCY = 12;

  typedef struct packed {
    logic signed [15:0] e;
    logic signed [15:0] m;
  } pf_type;

  typedef struct packed {
    logic signed [15:0] rc1;
    logic signed [15:0] rc2;
    logic [15:0] pred_err;
    pf_type threshold;
    logic [NLAG-1:0][15:0] coef;
    logic [NLAG-1:0][31:0] acf;
  } frame_in_type;

  typedef struct packed {
    logic done;
    logic busy;
    logic tone;
    logic vvad;
    logic below_floor;
    logic thr_below_floor;
    logic thr_above_margin;
    pf_type filtered_energy;
    pf_type input_energy;
  } result_type;

endpackage : vad_pkg

// >>> vad_pseudo_float_pole_test.sv
// Purpose: pole-frequency tone test, block-filter energy, voice decision
// Assumes: inputs synchronous to clk, frame held by a one-cycle start
// Notes: one frame in flight at a time; a start while busy is ignored
`timescale 1ns/1ps
`default_nettype none

module vad_pseudo_float_pole_test (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // frame request
  input wire logic start,
  input wire vad_pkg::frame_in_type frame_in,
  // frame result
  output vad_pkg::result_type result
);

  typedef enum logic [2:0] {S_IDLE, S_POLE, S_TEST, S_MAC, S_FIN} st_type;

  typedef struct packed {
    st_type st;
    vad_pkg::frame_in_type fr;
    logic signed [17:0] a1;
    logic signed [15:0] a2;
    logic signed [39:0] im;
    logic [3:0] idx;
    logic signed [vad_pkg::ACC_W-1:0] acc;
    vad_pkg::result_type res;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // a > b on pseudo-floats; zero mantissa is below everything
  function automatic logic pf_gt(vad_pkg::pf_type a, vad_pkg::pf_type b);
    if (a.m == 16'sh0000)
      return 1'b0;
    if (b.m == 16'sh0000)
      return 1'b1;
    if (a.e != b.e)
      return a.e > b.e;
    return a.m > b.m;
  endfunction : pf_gt

  // normalize a non-negative integer scaled by 2^-frac
  function automatic vad_pkg::pf_type pf_norm(
    logic signed [vad_pkg::ACC_W-1:0] v, int frac);
    vad_pkg::pf_type r;
    int p;
    logic [vad_pkg::ACC_W-1:0] sh;
    r.e = vad_pkg::ZERO_EXP;
    r.m = 16'sh0000;
    p = -1;
    for (int i = 0; i < vad_pkg::ACC_W; i++)
      if (v[i])
        p = i;
    if (v > 0)
    begin
      sh = vad_pkg::ACC_W'(v) << (vad_pkg::ACC_W - 1 - p);
      r.m = 16'(sh[vad_pkg::ACC_W-1 -: vad_pkg::MANT_FRAC]);
      r.e = 16'(p + 1 - frac);
    end
    return r;
  endfunction : pf_norm

  // sum of coefficient products spaced lag apart
  function automatic logic signed [35:0] coef_lag(
    logic [vad_pkg::NLAG-1:0][15:0] c, logic [3:0] lag);
    logic signed [35:0] s;
    s = '0;
    for (int k = 0; k < vad_pkg::NLAG; k++)
      if (k + int'(lag) < vad_pkg::NLAG)
        s = s + 36'($signed(c[k])) *
          36'($signed(c[k + int'(lag)]));
    return s;
  endfunction : coef_lag

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic signed [33:0] prod12;
    logic signed [39:0] a1sq;
    logic signed [63:0] lhs;
    logic signed [63:0] rhs;
    logic signed [67:0] mac;
    logic pole_pass;
    prod12 = '0;
    a1sq = '0;
    lhs = '0;
    rhs = '0;
    mac = '0;
    pole_pass = 1'b0;
    state_nxt = state_r;
    state_nxt.res.done = 1'b0;
    case (state_r.st)
      S_IDLE:
      begin
        if (start)
        begin
          state_nxt.fr = frame_in;
          state_nxt.res.busy = 1'b1;
          state_nxt.st = S_POLE;
        end
      end
      S_POLE:
      begin
        // step-up, order 2, leading coefficient one
        prod12 = 34'($signed(state_r.fr.rc1)) *
          34'($signed(state_r.fr.rc2));
        state_nxt.a1 = 18'(state_r.fr.rc1) + 18'(prod12 >>> 15);
        state_nxt.a2 = state_r.fr.rc2;
        state_nxt.st = S_TEST;
      end
      S_TEST:
      begin
        // im held as 4*im in Q30 so no halving error creeps in
        a1sq = 40'(state_r.a1) * 40'(state_r.a1);
        state_nxt.im = (40'(state_r.a2) <<< 17) - a1sq;
        lhs = 64'((40'(state_r.a2) <<< 17) - a1sq) <<< 15;
        rhs = 64'(a1sq) * 64'($signed({1'b0, vad_pkg::FREQTH_Q15}));
        if ((40'(state_r.a2) <<< 17) < a1sq)
          pole_pass = 1'b0;
        else if (state_r.a1 > 18'sh00000)
          pole_pass = 1'b1;
        else
          pole_pass = !(lhs < rhs);
        state_nxt.res.tone = pole_pass &&
          (state_r.fr.pred_err < vad_pkg::PREDTH_Q15);
        state_nxt.idx = '0;
        state_nxt.acc = '0;
        state_nxt.st = S_MAC;
      end
      S_MAC:
      begin
        // one multiply-accumulate per lag keeps a single wide multiplier
        mac = 68'(coef_lag(state_r.fr.coef, state_r.idx)) *
          68'($signed({1'b0, state_r.fr.acf[state_r.idx]}));
        if (state_r.idx != 4'h0)
          mac = mac <<< 1;
        state_nxt.acc = state_r.acc + vad_pkg::ACC_W'(mac);
        state_nxt.idx = state_r.idx + 4'h1;
        if (state_r.idx == 4'(vad_pkg::NLAG - 1))
          state_nxt.st = S_FIN;
      end
      S_FIN:
      begin
        state_nxt.res.filtered_energy =
          pf_norm(state_r.acc, vad_pkg::ENERGY_FRAC);
        state_nxt.res.input_energy = pf_norm(
          vad_pkg::ACC_W'($signed({1'b0, state_r.fr.acf[0]})), 0);
        state_nxt.res.vvad = pf_gt(pf_norm(state_r.acc,
          vad_pkg::ENERGY_FRAC), state_r.fr.threshold);
        state_nxt.res.below_floor = pf_gt(
          '{vad_pkg::E_FLOOR, vad_pkg::M_FLOOR}, pf_norm(
          vad_pkg::ACC_W'($signed({1'b0, state_r.fr.acf[0]})), 0));
        state_nxt.res.thr_below_floor = pf_gt('{vad_pkg::E_THFLOOR,
          vad_pkg::M_THFLOOR}, state_r.fr.threshold);
        state_nxt.res.thr_above_margin = pf_gt(state_r.fr.threshold,
          '{vad_pkg::E_MARGIN, vad_pkg::M_MARGIN});
        state_nxt.res.done = 1'b1;
        state_nxt.res.busy = 1'b0;
        state_nxt.st = S_IDLE;
      end
      default:
      begin
        state_nxt.st = S_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= '0;
      state_r.st <= S_IDLE;
      state_r.res.filtered_energy.e <= vad_pkg::ZERO_EXP;
      state_r.res.input_energy.e <= vad_pkg::ZERO_EXP;
    end
    else
      state_r <= state_nxt;
  end

  assign result = state_r.res;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_latency;
    @(posedge clk) disable iff (rst)
    (start && !result.busy) |=> !result.done [*8] ##1 !result.done [*4]
    ##1 result.done;
  endproperty
  a_latency: assert property (p_latency)
    else $error("done not 12 cycles after start");

  property p_exp_first;
    @(posedge clk) disable iff (rst)
    (result.done && result.filtered_energy.m != 16'sh0000 &&
     state_r.fr.threshold.m != 16'sh0000 &&
     result.filtered_energy.e != state_r.fr.threshold.e) |->
    (result.vvad == (result.filtered_energy.e > state_r.fr.threshold.e));
  endproperty
  a_exp_first: assert property (p_exp_first)
    else $error("decision not ordered by exponent");

  property p_mant_tie;
    @(posedge clk) disable iff (rst)
    (result.done && result.filtered_energy.m != 16'sh0000 &&
     result.filtered_energy.e == state_r.fr.threshold.e) |->
    (result.vvad == (result.filtered_energy.m > state_r.fr.threshold.m));
  endproperty
  a_mant_tie: assert property (p_mant_tie)
    else $error("equal exponents not decided by mantissa");

  property p_norm;
    @(posedge clk) disable iff (rst)
    (result.done && result.filtered_energy.m != 16'sh0000) |->
    (result.filtered_energy.m >= vad_pkg::MANT_MIN);
  endproperty
  a_norm: assert property (p_norm)
    else $error("mantissa not normalized");

  property p_im_neg;
    @(posedge clk) disable iff (rst)
    (result.done && state_r.im < 40'sh0) |-> !result.tone;
  endproperty
  a_im_neg: assert property (p_im_neg)
    else $error("tone with negative imaginary term");

  property p_pred;
    @(posedge clk) disable iff (rst)
    (result.done && result.tone) |->
    (state_r.fr.pred_err < vad_pkg::PREDTH_Q15);
  endproperty
  a_pred: assert property (p_pred)
    else $error("tone with large prediction error");

  property p_high_freq;
    @(posedge clk) disable iff (rst)
    (result.done && state_r.im >= 40'sh0 && state_r.a1 > 18'sh0 &&
     state_r.fr.pred_err < vad_pkg::PREDTH_Q15) |-> result.tone;
  endproperty
  a_high_freq: assert property (p_high_freq)
    else $error("high pole frequency not passed to error test");

  property p_step_up;
    @(posedge clk) disable iff (rst)
    (state_r.st == S_POLE) |=>
    (state_r.a2 == $past(state_r.fr.rc2)) ##1 (state_r.st == S_MAC);
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("second coefficient not taken from reflection input");

  property p_floor;
    @(posedge clk) disable iff (rst)
    (result.done && result.input_energy.m == 16'sh0000) |->
    result.below_floor;
  endproperty
  a_floor: assert property (p_floor)
    else $error("zero energy not below floor");

  property p_busy_done;
    @(posedge clk) disable iff (rst)
    result.done |-> !result.busy;
  endproperty
  a_busy_done: assert property (p_busy_done)
    else $error("busy still high with done");

  property p_mac_len;
    @(posedge clk) disable iff (rst)
    (state_r.st == S_MAC && state_r.idx == 4'(vad_pkg::NLAG - 1)) |=>
    (state_r.st == S_FIN);
  endproperty
  a_mac_len: assert property (p_mac_len)
    else $error("lag accumulation not nine steps");

  property p_zero_small;
    @(posedge clk) disable iff (rst)
    (result.done && result.filtered_energy.m == 16'sh0000) |->
    !result.vvad;
  endproperty
  a_zero_small: assert property (p_zero_small)
    else $error("zero energy judged above threshold");

  property p_in_norm;
    @(posedge clk) disable iff (rst)
    (result.done && result.input_energy.m != 16'sh0000) |->
    (result.input_energy.m >= vad_pkg::MANT_MIN);
  endproperty
  a_in_norm: assert property (p_in_norm)
    else $error("input energy mantissa not normalized");

endmodule : vad_pseudo_float_pole_test

`default_nettype wire

// >>> frame_source.sv
// Purpose: encoder analysis stage model that hands one frame to the block
// Assumes: clk is the block clock, one-cycle start
// Notes: frame lines are scrambled once the start cycle has passed
`timescale 1ns/1ps
`default_nettype none

module frame_source (
  // clock
  input wire logic clk,
  // request to the block
  output var logic start,
  output var vad_pkg::frame_in_type frame_in
);
  initial
  begin
    start = 1'b0;
    frame_in = '0;
  end

  task automatic send(input vad_pkg::frame_in_type f);
    @(negedge clk);
    start = 1'b1;
    frame_in = f;
    @(negedge clk);
    start = 1'b0;
    // stale data must never pass for a held frame
    frame_in = ~f;
  endtask : send
endmodule : frame_source

`default_nettype wire

// >>> vad_pseudo_float_pole_test_tb.sv
// Purpose: self-checking bench for the pole test and energy datapath
// Assumes: 20 MHz clock, frames from the source model
// Notes: energies use coef[0]=1.0 plus one extra tap for simple sums
`timescale 1ns/1ps
`default_nettype none

module vad_pseudo_float_pole_test_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start;
  vad_pkg::frame_in_type frame_in;
  vad_pkg::result_type result;
  int fail_count = 0;
  int checks_done = 0;

  always #25 clk = ~clk;

  frame_source src (.clk(clk), .start(start), .frame_in(frame_in));
  vad_pseudo_float_pole_test dut (.clk(clk), .rst(rst), .start(start),
    .frame_in(frame_in), .result(result));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  function automatic vad_pkg::pf_type to_pf(input longint v);
    int n;
    to_pf = {16'h8000, 16'h0000};
    n = 0;
    if (v > 0)
    begin
      while ((v >> n) != 0)
        n++;
      to_pf.e = 16'(n);
      to_pf.m = (n >= 15) ? 16'(v >> (n - 15)) : 16'(v << (15 - n));
    end
  endfunction : to_pf

  function automatic vad_pkg::frame_in_type mkf(input logic [15:0] r1,
      input logic [15:0] r2, input logic [15:0] pr, input logic [31:0] th,
      input logic [31:0] a0);
    mkf = '0;
    mkf.rc1 = r1;
    mkf.rc2 = r2;
    mkf.pred_err = pr;
    mkf.threshold = th;
    mkf.coef[0] = 16'h1000;
    mkf.acf[0] = a0;
  endfunction : mkf

  // sends a frame, judges busy and the done latency
  task automatic run_frame(input vad_pkg::frame_in_type f);
    int n;
    n = 0;
    src.send(f);
    check(32'(result.busy), 32'h1);
    while (result.done !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(32'(n), 32'hC);
    check(32'(result.busy), 32'h0);
  endtask : run_frame

  task automatic t_reset();
    check(result.filtered_energy, 32'h80000000);
    check(result.input_energy, 32'h80000000);
    check(32'({result.done, result.busy, result.vvad}), 32'h0);
  endtask : t_reset

  // a start while busy must be dropped silently
  task automatic t_refuse();
    int k;
    k = 0;
    src.send(mkf(16'h0000, 16'h0000, 16'h0000, 32'h0, 32'h10000));
    repeat (3) @(posedge clk);
    src.send(mkf(16'h0000, 16'h0000, 16'h0000, 32'h0, 32'h1FBD0));
    repeat (14)
    begin
      @(posedge clk);
      #1;
      if (result.done === 1'b1)
        k++;
    end
    check(32'(k), 32'h1);
    check(result.input_energy, to_pf(64'h10000));
  endtask : t_refuse

  task automatic e_case(input int i, input logic [15:0] cv,
      input logic [31:0] a0, input logic [31:0] av);
    vad_pkg::frame_in_type f;
    longint ex;
    f = mkf(16'h0000, 16'h0000, 16'h0000, 32'h80000000, a0);
    f.coef[i] = cv;
    f.acf[i] = av;
    ex = ((64'd16777216 + longint'(cv) * cv) * a0
      + 2 * 4096 * longint'(cv) * av) >> 24;
    run_frame(f);
    check(result.filtered_energy, to_pf(ex));
    check(result.input_energy, to_pf(longint'(a0)));
    check(32'(result.below_floor), 32'(a0 < 32'h1FBD0));
    check(32'(result.vvad), 32'(ex > 0));
  endtask : e_case

  task automatic t_energy();
    e_case(1, 16'h0000, 32'h10000, 32'h0);
    e_case(1, 16'h1000, 32'h10000, 32'h8000);
    e_case(8, 16'h0800, 32'h10000, 32'h4000);
    e_case(1, 16'h0000, 32'h1FBD0, 32'h0);
    e_case(1, 16'h0000, 32'h1FBCC, 32'h0);
    e_case(1, 16'h0000, 32'h0, 32'h0);
  endtask : t_energy

  // energy is (17,24576) in every case
  task automatic c_case(input logic [31:0] th, input logic [2:0] exp);
    run_frame(mkf(16'h0000, 16'h0000, 16'h0000, th, 32'h18000));
    check(32'({result.vvad, result.thr_below_floor,
      result.thr_above_margin}), 32'(exp));
  endtask : c_case

  task automatic t_compare();
    c_case({16'h0011, 16'h5FFF}, 3'h6);
    c_case({16'h0011, 16'h6000}, 3'h2);
    c_case({16'h0012, 16'h4000}, 3'h2);
    c_case({16'h0010, 16'h7FFF}, 3'h6);
    c_case({16'h0013, 16'h54A3}, 3'h0);
    c_case({16'h0013, 16'h54A2}, 3'h2);
    c_case({16'h001B, 16'h421F}, 3'h0);
    c_case({16'h001B, 16'h4220}, 3'h1);
  endtask : t_compare

  task automatic o_case(input logic [15:0] r1, input logic [15:0] r2,
      input logic [15:0] pr, input logic exp);
    run_frame(mkf(r1, r2, pr, 32'h80000000, 32'h10000));
    check(32'(result.tone), 32'(exp));
  endtask : o_case

  task automatic t_tone();
    o_case(16'h0000, 16'h2000, 16'h05B8, 1'b1);
    o_case(16'h0000, 16'h2000, 16'h05B9, 1'b0);
    o_case(16'h4000, 16'h0000, 16'h0000, 1'b0);
    o_case(16'hC000, 16'h0000, 16'h0000, 1'b0);
    o_case(16'h4000, 16'h4000, 16'h0000, 1'b1);
    o_case(16'hC000, 16'h4000, 16'h0000, 1'b1);
    o_case(16'h8300, 16'h7148, 16'h0000, 1'b0);
    o_case(16'h7D00, 16'h7148, 16'h0000, 1'b1);
  endtask : t_tone

  initial
  begin
    // 24 frames of about 13 cycles; generous margin
    #(2000 * 50);
    fail_count++;
    test_done();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_refuse();
    t_energy();
    t_compare();
    t_tone();
    test_done();
  end
endmodule : vad_pseudo_float_pole_test_tb

`default_nettype wire
